// ===== logic/bps_defines.vh
`ifndef BPS_DEFINES_VH
`define BPS_DEFINES_VH

// Clock rate in kHz (200 MHz system clock)
`define BPS_CLK_KHZ           200000
// Filter, blanking and auto-recovery times in microseconds
`define BPS_BULK_FILT_US      20
`define BPS_OVP_FILT_US       10
`define BPS_OTP_FILT_US       40
`define BPS_OTP_BLANK_US      1000
`define BPS_AUTOREC_US        100000
// Derived cycle counts (least times, rounded up)
`define BPS_BULK_FILT_CYC     ((`BPS_BULK_FILT_US * `BPS_CLK_KHZ + 999) / 1000)
`define BPS_OVP_FILT_CYC      ((`BPS_OVP_FILT_US * `BPS_CLK_KHZ + 999) / 1000)
`define BPS_OTP_FILT_CYC      ((`BPS_OTP_FILT_US * `BPS_CLK_KHZ + 999) / 1000)
`define BPS_OTP_BLANK_CYC     ((`BPS_OTP_BLANK_US * `BPS_CLK_KHZ + 999) / 1000)
`define BPS_AUTOREC_CYC       ((`BPS_AUTOREC_US * `BPS_CLK_KHZ + 999) / 1000)
// Counter width shared by all timers
`define BPS_CNT_W             25
// Fault states, one-hot
`define BPS_ST_W              3
`define BPS_ST_RUN            3'h1
`define BPS_ST_AUTO           3'h2
`define BPS_ST_LATCH          3'h4

`endif

// ===== logic/bps_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "bps_defines.vh"

// Debounce: output follows input only after it has been stable for cycles
module bps_filter (
   input  wire                  clk_sys,
   input  wire                  rst_n,
   input  wire [`BPS_CNT_W-1:0] cycles,
   input  wire                  din,
   output reg                   dout
);

   reg [`BPS_CNT_W-1:0] count;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count <= {`BPS_CNT_W{1'b0}};
         dout  <= 1'b0;
      end else if (din == dout) begin
         count <= {`BPS_CNT_W{1'b0}};
      end else if (count >= cycles - 1'b1) begin
         count <= {`BPS_CNT_W{1'b0}};
         dout  <= din;
      end else begin
         count <= count + 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== logic/bps_supervisor.v
`timescale 1ns/1ps
`default_nettype none
`include "bps_defines.vh"

module bps_supervisor #(
   parameter OVP_LATCH     = 1'b1,
   parameter OTP_LATCH     = 1'b1,
   parameter AUTOREC_CYC   = `BPS_AUTOREC_CYC,
   parameter OTP_BLANK_CYC = `BPS_OTP_BLANK_CYC
) (
   input  wire clk_sys,
   input  wire rst_n,
   input  wire bulkCmp,
   input  wire overVoltCmp,
   input  wire overTempCmp,
   input  wire supplyAboveStart,
   input  wire supplyAboveStop,
   input  wire skipActive,
   input  wire offModeActive,
   output reg  hysteresisSink,
   output reg  bulkDischarge,
   output reg  tempSenseOn,
   output reg  tempSenseBoost,
   output reg  protectionEnable,
   output reg  runAllowed,
   output reg  selfSupplyCycling,
   output reg  faultLatched,
   output reg  faultAutoRec
);

   // rst_n is held while supply is under the reset level, so reset
   // itself is the only way out of the latched state.
   localparam [`BPS_CNT_W-1:0] BULK_CYC = `BPS_BULK_FILT_CYC;
   localparam [`BPS_CNT_W-1:0] OVP_CYC  = `BPS_OVP_FILT_CYC;
   localparam [`BPS_CNT_W-1:0] OTP_CYC  = `BPS_OTP_FILT_CYC;
   localparam [`BPS_CNT_W-1:0] AR_CYC   = AUTOREC_CYC;
   localparam [`BPS_CNT_W-1:0] BLK_CYC  = OTP_BLANK_CYC;

   reg  [8:0] syncA;
   reg  [8:0] syncB;
   wire [8:0] rawIn;
   assign rawIn = {2'h0, offModeActive, skipActive, supplyAboveStop, supplyAboveStart,
                   overTempCmp, overVoltCmp, bulkCmp};

   genvar i;
   generate
      for (i = 0; i < 9; i = i + 1) begin : gSync
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               syncA[i] <= 1'b0;
               syncB[i] <= 1'b0;
            end else begin
               syncA[i] <= rawIn[i];
               syncB[i] <= syncA[i];
            end
         end
      end
   endgenerate

   wire sBulk  = syncB[0];
   wire sOvp   = syncB[1];
   wire sOtp   = syncB[2];
   wire sStart = syncB[3];
   wire sStop  = syncB[4];
   wire sSkip  = syncB[5];
   wire sOff   = syncB[6];

   wire bulkGood;
   wire ovpFilt;
   wire otpFilt;

   bps_filter uBulk (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cycles  (BULK_CYC),
      .din     (sBulk),
      .dout    (bulkGood)
   );

   bps_filter uOvp (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cycles  (OVP_CYC),
      .din     (sOvp),
      .dout    (ovpFilt)
   );

   // Blanking masks the raw comparator before its filter, so the filter
   // starts fresh when blanking ends instead of firing at once.
   reg  blanking;
   bps_filter uOtp (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .cycles  (OTP_CYC),
      .din     (sOtp & ~blanking),
      .dout    (otpFilt)
   );

   reg started;
   reg prevBulk;
   reg prevStop;
   reg prevSkip;
   reg prevOff;
   reg [`BPS_ST_W-1:0]  state;
   reg [`BPS_ST_W-1:0]  next_state;
   reg [`BPS_CNT_W-1:0] arCount;
   reg [`BPS_CNT_W-1:0] blankCount;
   reg arDone;

   wire startEvt  = sStart & ~started;
   wire bulkRise  = bulkGood & ~prevBulk;
   wire bulkFall  = ~bulkGood & prevBulk;
   wire stopFall  = ~sStop & prevStop;
   wire skipExit  = ~sSkip & prevSkip;
   wire skipEnter = sSkip & ~prevSkip;
   wire offExit   = ~sOff & prevOff;
   wire offEnter  = sOff & ~prevOff;
   // A filtered fault counts only while the comparator still reports it,
   // so the slow release of the filter cannot re-trip an auto-recovery restart.
   // Limitation: a fault that returns within one filter time is not re-filtered.
   wire ovpFault  = ovpFilt & sOvp;
   wire otpFault  = otpFilt & sOtp & ~blanking;
   wire inWindow  = ~ovpFault & ~otpFault;
   wire faultHit  = protectionEnable & ~inWindow & (state == `BPS_ST_RUN);
   wire doLatch   = (ovpFault & OVP_LATCH) | (otpFault & ~ovpFault & OTP_LATCH);

   always @* begin
      next_state = state;
      arDone     = 1'b0;
      case (state)
         `BPS_ST_RUN: begin
            if (faultHit) begin
               next_state = doLatch ? `BPS_ST_LATCH : `BPS_ST_AUTO;
            end
         end
         `BPS_ST_AUTO: begin
            if (arCount >= AR_CYC - 1'b1) begin
               next_state = `BPS_ST_RUN;
               arDone     = 1'b1;
            end
         end
         `BPS_ST_LATCH: begin
            next_state = `BPS_ST_LATCH;
         end
         default: begin
            next_state = `BPS_ST_RUN;
         end
      endcase
   end

   wire enSet = startEvt | bulkRise | arDone | skipExit | offExit;
   wire enClr = stopFall | bulkFall | faultHit | skipEnter | offEnter;

   // Edge history and fault state
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         started  <= 1'b0;
         prevBulk <= 1'b0;
         prevStop <= 1'b0;
         prevSkip <= 1'b0;
         prevOff  <= 1'b0;
         state    <= `BPS_ST_RUN;
      end else begin
         prevBulk <= bulkGood;
         prevStop <= sStop;
         prevSkip <= sSkip;
         prevOff  <= sOff;
         state    <= next_state;
         if (startEvt) begin
            started <= 1'b1;
         end
      end
   end

   // Auto-recovery timer runs only while waiting to restart
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         arCount <= {`BPS_CNT_W{1'b0}};
      end else if (next_state == `BPS_ST_AUTO) begin
         arCount <= arCount + 1'b1;
      end else begin
         arCount <= {`BPS_CNT_W{1'b0}};
      end
   end

   // Discharge held until first start level crossing
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bulkDischarge  <= 1'b1;
         hysteresisSink <= 1'b0;
      end else begin
         bulkDischarge  <= ~(started | startEvt);
         hysteresisSink <= (started | startEvt) & ~bulkGood;
      end
   end

   // Set wins over clear when both arrive in one cycle
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         protectionEnable <= 1'b0;
      end else if (enSet) begin
         protectionEnable <= 1'b1;
      end else if (enClr) begin
         protectionEnable <= 1'b0;
      end
   end

   // Each enable restarts blanking, so a restart never sees a stale cap charge
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tempSenseOn <= 1'b0;
         blanking    <= 1'b0;
         blankCount  <= {`BPS_CNT_W{1'b0}};
      end else if (enClr & ~enSet) begin
         tempSenseOn <= 1'b0;
         blanking    <= 1'b0;
      end else if (enSet) begin
         tempSenseOn <= 1'b1;
         blanking    <= 1'b1;
         blankCount  <= {`BPS_CNT_W{1'b0}};
      end else if (blanking) begin
         if (blankCount >= BLK_CYC - 1'b1) begin
            blanking <= 1'b0;
         end else begin
            blankCount <= blankCount + 1'b1;
         end
      end
   end

   // Boost current only while the filter cap charges
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tempSenseBoost <= 1'b0;
      end else begin
         tempSenseBoost <= (enSet | blanking) & ~(enClr & ~enSet);
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         runAllowed <= 1'b0;
      end else begin
         runAllowed <= started & bulkGood & inWindow & sStop & ~sSkip & ~sOff
                       & (next_state == `BPS_ST_RUN);
      end
   end

   // Mode outputs follow the next state so they line up with runAllowed
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         selfSupplyCycling <= 1'b0;
         faultLatched      <= 1'b0;
         faultAutoRec      <= 1'b0;
      end else begin
         selfSupplyCycling <= (next_state != `BPS_ST_RUN) | sOff;
         faultLatched      <= (next_state == `BPS_ST_LATCH);
         faultAutoRec      <= (next_state == `BPS_ST_AUTO);
      end
   end

endmodule
`default_nettype wire

// ===== sim/bps_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side comparators; thresholds are neutral test levels
module bps_analog_model #(
   parameter logic [9:0] BULK_ON = 10'h1f4,
   parameter logic [9:0] OVP_THR = 10'h320,
   parameter logic [9:0] OTP_THR = 10'h0c8,
   parameter logic [9:0] START   = 10'h2bc,
   parameter logic [9:0] STOP    = 10'h190
) (
   input  wire logic [9:0] bulkSense,
   input  wire logic [9:0] protPin,
   input  wire logic [9:0] supplyLevel,
   output logic            bulkCmp,
   output logic            overVoltCmp,
   output logic            overTempCmp,
   output logic            supplyAboveStart,
   output logic            supplyAboveStop
);
   assign bulkCmp = bulkSense >= BULK_ON;
   assign overVoltCmp = protPin > OVP_THR;
   assign overTempCmp = protPin < OTP_THR;
   assign supplyAboveStart = supplyLevel >= START;
   assign supplyAboveStop = supplyLevel > STOP;
endmodule
`default_nettype wire

// ===== sim/bps_supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module bps_supervisor_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bulkCmp,
   input wire logic overVoltCmp,
   input wire logic overTempCmp,
   input wire logic supplyAboveStart,
   input wire logic supplyAboveStop,
   input wire logic skipActive,
   input wire logic offModeActive,
   input wire logic hysteresisSink,
   input wire logic bulkDischarge,
   input wire logic tempSenseOn,
   input wire logic tempSenseBoost,
   input wire logic protectionEnable,
   input wire logic runAllowed,
   input wire logic selfSupplyCycling,
   input wire logic faultLatched,
   input wire logic faultAutoRec
);
   logic [11:0] hiCnt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Saturates so a long fault never wraps back under the filter count
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) hiCnt <= 12'h000;
      else if (!(overVoltCmp || overTempCmp)) hiCnt <= 12'h000;
      else if (hiCnt != 12'hfff) hiCnt <= hiCnt + 12'h001;
   a_latch_no_run: assert property (faultLatched |-> !runAllowed && !tempSenseOn) else $error("run in latch");
   a_latch_holds: assert property (faultLatched |=> faultLatched) else $error("latch cleared");
   a_sink_off_run: assert property (runAllowed |-> !hysteresisSink) else $error("sink while run");
   a_discharge_stop: assert property (bulkDischarge |-> !runAllowed) else $error("run in startup");
   a_release_start: assert property ($fell(bulkDischarge) |-> protectionEnable && tempSenseBoost)
      else $error("start events");
   a_stop_halts: assert property ((!supplyAboveStop) [*6] |-> !runAllowed && !tempSenseOn)
      else $error("stop level ignored");
   a_skip_halts: assert property (skipActive [*6] |-> !runAllowed && !tempSenseOn) else $error("skip ignored");
   a_fault_filter: assert property ($rose(faultLatched || faultAutoRec) |-> hiCnt >= 12'd2000)
      else $error("fault too early");
endmodule
bind bps_supervisor bps_supervisor_props chk (.*);
`default_nettype wire

// ===== sim/bps_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bps_supervisor_tb;
   logic       clk_sys, rst_n, skipActive, offModeActive;
   logic [9:0] bulkSense, protPin, supplyLevel;
   wire        bulkCmp, overVoltCmp, overTempCmp, supplyAboveStart, supplyAboveStop;
   wire        hysteresisSink, bulkDischarge, tempSenseOn, tempSenseBoost, protectionEnable;
   wire        runAllowed, selfSupplyCycling, faultLatched, faultAutoRec;
   int         err_count = 0;
   int         n_checks = 0;
   bps_analog_model ana (.*);
   bps_supervisor #(.OVP_LATCH(1'b1), .OTP_LATCH(1'b0), .AUTOREC_CYC(50), .OTP_BLANK_CYC(20)) dut (.*);
   task automatic test_done;
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Bounded wait on one output; a hang ends the run
   task automatic waitFor(input int b, input int lim);
      logic [3:0] seen;
      repeat (lim) begin
         seen = {faultAutoRec, faultLatched, runAllowed, protectionEnable};
         if (seen[b] === 1'b1) return;
         @(posedge clk_sys);
      end
      chk(1'b0, "wait timed out");
      test_done();
   endtask
   task automatic s_start;
      chk(bulkDischarge === 1'b1 && protectionEnable === 1'b0, "no discharge");
      supplyLevel <= 10'h320;
      cyc(6);
      chk(bulkDischarge === 1'b0 && hysteresisSink === 1'b1, "start release");
      chk(protectionEnable === 1'b1 && tempSenseBoost === 1'b1 && tempSenseOn === 1'b1, "enable");
      cyc(30);
      chk(tempSenseBoost === 1'b0 && runAllowed === 1'b0, "boost stuck");
   endtask
   task automatic s_bulk;
      bulkSense <= 10'h258;
      cyc(3990);
      chk(runAllowed === 1'b0, "bulk filter short");
      waitFor(1, 40);
      chk(hysteresisSink === 1'b0, "sink on");
      bulkSense <= 10'h064;
      cyc(100);
      bulkSense <= 10'h258;
      cyc(4100);
      chk(runAllowed === 1'b1, "glitch passed");
   endtask
   task automatic s_modes;
      for (int i = 0; i < 2; i++) begin
         {offModeActive, skipActive} <= 2'b01 << i;
         cyc(6);
         chk(runAllowed === 1'b0 && tempSenseOn === 1'b0, "mode entry");
         {offModeActive, skipActive} <= 2'b00;
         cyc(6);
         chk(protectionEnable === 1'b1 && tempSenseOn === 1'b1, "mode exit");
      end
   endtask
   task automatic s_faults;
      protPin <= 10'h064;
      cyc(7990);
      chk(runAllowed === 1'b1, "otp filter short");
      waitFor(3, 40);
      chk(faultLatched === 1'b0 && tempSenseOn === 1'b0, "otp mode");
      protPin <= 10'h1f4;
      waitFor(1, 300);
      chk(faultAutoRec === 1'b0 && protectionEnable === 1'b1, "restart");
      protPin <= 10'h3e8;
      cyc(1990);
      chk(runAllowed === 1'b1, "ovp filter short");
      waitFor(2, 40);
      chk(runAllowed === 1'b0 && selfSupplyCycling === 1'b1, "ovp latch");
      protPin <= 10'h1f4;
      supplyLevel <= 10'h12c;
      cyc(10);
      supplyLevel <= 10'h320;
      cyc(10);
      chk(faultLatched === 1'b1 && runAllowed === 1'b0, "latch lost");
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      waitFor(1, 4100);
      chk(faultLatched === 1'b0, "latch kept");
      bulkSense <= 10'h064;
      cyc(4010);
      chk(hysteresisSink === 1'b1 && tempSenseOn === 1'b0, "brown-out");
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      rst_n = 1'b0;
      {offModeActive, skipActive} = 2'b00;
      bulkSense = 10'h000;
      protPin = 10'h1f4;
      supplyLevel = 10'h000;
      cyc(4);
      rst_n <= 1'b1;
      cyc(8);
      s_start();
      s_bulk();
      s_modes();
      s_faults();
      test_done();
   end
endmodule
`default_nettype wire
